// ===== common/arr_defs.vh
// register offsets, reset values and limits of the converter register block
`ifndef ARR_DEFS_VH
`define ARR_DEFS_VH
`define ARR_OFS_DBG      6'h0c
`define ARR_OFS_SHADOW   6'h0d
`define ARR_OFS_RES_LO   6'h10
`define ARR_OFS_RES_HI   6'h11
`define ARR_OFS_FLAGS    6'h0b
`define ARR_RST_DBG      8'h00
`define ARR_RST_SHADOW   8'h00
`define ARR_RST_RES      16'h0000
`define ARR_BIT_RUN      0
`define ARR_BIT_RDY      0
`define ARR_BIT_WIN      1
`define ARR_SAMPLE_MAX   10'h3ff
`define ARR_SAMPLE_MIN   10'h000
`define ARR_ACC_MAX      16'hffc0
`define ARR_ACC_COUNT    7'h40
`endif

// ===== rtl/arr_sample_clamp.v
// clamps one raw signed converter code into the 10-bit sample range
`timescale 1ns/1ps
`include "arr_defs.vh"
module arr_sample_clamp (
  // raw code, two bits wider than the sample, signed
  input  wire signed [11:0] raw_i,
  // clamped sample
  output reg         [9:0]  sample_o
);
  // ------------------------------------------------------------
  // saturation
  // ------------------------------------------------------------
  // combinational clamp of one raw code
  always @* begin
    if (raw_i < 12'sh000) begin
      sample_o = `ARR_SAMPLE_MIN;
    end else if (raw_i > 12'sh3ff) begin
      sample_o = `ARR_SAMPLE_MAX;
    end else begin
      sample_o = raw_i[9:0];
    end
  end
endmodule

// ===== rtl/arr_regs.v
// result, shadow byte and debug-run register logic of the converter
`timescale 1ns/1ps
`include "arr_defs.vh"
// What this block does
// - halted without run bit: stop, ignore events
// - run bit set: keep running while halted
// - one shadow byte shared by 16-bit registers
// - shadow byte readable, writable, resets zero
// - result low byte base, high byte plus one
// - sample saturates at all ones
// - sample below ground clamps to zero
// - at most 64 samples, sum capped
// - result read clears ready and match flags
module arr_regs #(
  parameter [6:0] ACC_LIMIT = `ARR_ACC_COUNT  // most samples summed
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              rst_b_i,
  // register port
  input  wire [5:0]        addr_i,
  input  wire [7:0]        wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [7:0]        rdata_o,
  // debug halt from the core
  input  wire              cpu_halted_i,
  // converter side
  input  wire              event_i,
  input  wire              sample_valid_i,
  input  wire signed [11:0] sample_raw_i,
  input  wire [6:0]        acc_count_i,
  input  wire              window_hit_i,
  // status towards the rest of the converter
  output reg               run_o,
  output reg               event_o,
  output reg               result_ready_flag_o,
  output reg               window_match_flag_o,
  output reg  [15:0]       conversion_result_o
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg  [7:0]  debug_halt_control;   // bit 0 is run_while_halted
  reg  [7:0]  shadow_byte_buffer;   // the one shared shadow byte
  reg  [15:0] acc;                  // running sum
  reg  [6:0]  acc_n;                // samples in the sum
  wire [9:0]  sample;               // clamped sample
  wire        run_now;              // converter allowed to work
  wire [6:0]  lim;                  // effective sample limit
  reg  [15:0] next_acc;             // sum after this sample
  reg         done;                 // last sample of a result
  reg         clr_rdy;              // flag clear for ready
  reg         clr_win;              // flag clear for match

  // ------------------------------------------------------------
  // usage notes
  // ------------------------------------------------------------
  // the core reaches this block one byte at a time, so a 16-bit
  // value needs two accesses; the shared shadow byte keeps the two
  // halves of one result together even if a new result lands in
  // between the low and the high read.
  // limitation: the shadow byte is shared, so an interrupt handler
  // that reads a 16-bit register between the two halves of another
  // access spoils the first access; handlers must save and restore
  // the shadow byte themselves.
  // trade-off: read data is registered, one cycle of latency bought
  // a clean flop-driven output towards the core.
  // the result is only written at the end of a full accumulation,
  // so the core never sees a partial sum.
  // flags are sticky; a set in the same cycle as any clear wins, so
  // a result finishing during a read is never lost.
  // samples and events are both gated by the same run condition, so
  // a halted core with the run bit clear sees a frozen converter.

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // true when the offset selects either byte of the result
  function is_result;
    input [5:0] a;              // offset under test
    begin
      is_result = (a == `ARR_OFS_RES_LO) || (a == `ARR_OFS_RES_HI);
    end
  endfunction

  arr_sample_clamp u_clamp (
    .raw_i    (sample_raw_i),
    .sample_o (sample)
  );

  // halted core with run bit clear freezes the converter
  assign run_now = ~cpu_halted_i
                 | debug_halt_control[`ARR_BIT_RUN];
  // never more than the allowed count, zero counts as one
  assign lim = (acc_count_i == 7'h00) ? 7'h01 :
               (acc_count_i > ACC_LIMIT) ? ACC_LIMIT : acc_count_i;

  // ------------------------------------------------------------
  // accumulation
  // ------------------------------------------------------------
  // sum and done decision for the sample of this cycle
  always @* begin
    next_acc = acc + {6'h00, sample};
    if (next_acc > `ARR_ACC_MAX) begin
      next_acc = `ARR_ACC_MAX;
    end
    done = sample_valid_i & run_now & ((acc_n + 7'h01) >= lim);
  end

  // flag clears: write one or read of either result byte
  always @* begin
    clr_rdy = 1'b0;
    clr_win = 1'b0;
    // reading either byte counts as reading the result
    if (rd_i && is_result(addr_i)) begin
      clr_rdy = 1'b1;
      clr_win = 1'b1;
    end else if (wr_i && addr_i == `ARR_OFS_FLAGS) begin
      clr_rdy = wdata_i[`ARR_BIT_RDY];
      clr_win = wdata_i[`ARR_BIT_WIN];
    end
  end

  // sum, result and flags; a set in the clear cycle wins
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc                 <= 16'h0000;
      acc_n               <= 7'h00;
      conversion_result_o <= `ARR_RST_RES;
      result_ready_flag_o <= 1'b0;
      window_match_flag_o <= 1'b0;
    end else begin
      if (sample_valid_i && run_now) begin
        if (done) begin
          conversion_result_o <= next_acc;
          acc                 <= 16'h0000;
          acc_n               <= 7'h00;
        end else begin
          acc   <= next_acc;
          acc_n <= acc_n + 7'h01;
        end
      end
      if (done) begin
        result_ready_flag_o <= 1'b1;
      end else if (clr_rdy) begin
        result_ready_flag_o <= 1'b0;
      end
      if (done && window_hit_i) begin
        window_match_flag_o <= 1'b1;
      end else if (clr_win) begin
        window_match_flag_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // register writes and reads
  // ------------------------------------------------------------
  // debug control, shadow byte and low-read latch of the high byte
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      debug_halt_control <= `ARR_RST_DBG;
      shadow_byte_buffer <= `ARR_RST_SHADOW;
    end else begin
      if (wr_i && addr_i == `ARR_OFS_DBG) begin
        debug_halt_control <= {7'h00, wdata_i[`ARR_BIT_RUN]};
      end else if (wr_i && addr_i == `ARR_OFS_SHADOW) begin
        shadow_byte_buffer <= wdata_i;
      end
      if (rd_i && addr_i == `ARR_OFS_RES_LO) begin
        // later high read sees the same result
        shadow_byte_buffer <= conversion_result_o[15:8];
      end else if (wr_i && addr_i == `ARR_OFS_RES_LO) begin
        // result is read only; low byte still parks in shadow
        shadow_byte_buffer <= wdata_i;
      end
    end
  end

  // registered read data and run outputs
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
      run_o   <= 1'b0;
      event_o <= 1'b0;
    end else begin
      run_o   <= run_now;
      event_o <= event_i & run_now;
      if (!rd_i) begin
        rdata_o <= 8'h00;
      end else if (addr_i == `ARR_OFS_DBG) begin
        rdata_o <= debug_halt_control;
      end else if (addr_i == `ARR_OFS_SHADOW) begin
        rdata_o <= shadow_byte_buffer;
      end else if (addr_i == `ARR_OFS_RES_LO) begin
        rdata_o <= conversion_result_o[7:0];
      end else if (addr_i == `ARR_OFS_RES_HI) begin
        rdata_o <= shadow_byte_buffer;
      end else if (addr_i == `ARR_OFS_FLAGS) begin
        rdata_o <= {6'h00, window_match_flag_o, result_ready_flag_o};
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end
endmodule

// ===== bench/arr_regs_props.sv
// port checker of the converter register block
`timescale 1ns/1ps
module arr_regs_props #(parameter [6:0] ACC_LIMIT = 7'h40) (
  input wire        clk_i, rst_b_i, wr_i, rd_i, cpu_halted_i,
  input wire        event_i, sample_valid_i, run_o, event_o,
  input wire        result_ready_flag_o, window_match_flag_o,
  input wire [5:0]  addr_i,
  input wire [7:0]  wdata_i, rdata_o,
  input wire [15:0] conversion_result_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // low result byte read, then the high byte right behind it
  sequence s_lo; rd_i && addr_i == 6'h10; endsequence
  sequence s_pair; s_lo ##1 (rd_i && addr_i == 6'h11); endsequence
  property p_cap; conversion_result_o <= 16'hffc0; endproperty
  a_cap: assert property (p_cap) else $error("result over cap");
  property p_clr; rd_i && addr_i[5:1] == 5'h08 && !sample_valid_i
    && !$past(sample_valid_i) |=> !result_ready_flag_o
    && !window_match_flag_o; endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
  property p_run; !cpu_halted_i ##1 !cpu_halted_i |-> run_o; endproperty
  a_run: assert property (p_run) else $error("not running");
  // run_o lags run_now by one edge, just as event_o lags event_i
  property p_stop; cpu_halted_i && event_i |=> event_o == run_o;
  endproperty
  a_stop: assert property (p_stop) else $error("event passed");
  property p_evt; event_o |-> $past(event_i); endproperty
  a_evt: assert property (p_evt) else $error("stray event");
  property p_lo; s_lo |=> rdata_o == $past(conversion_result_o[7:0]);
  endproperty
  a_lo: assert property (p_lo) else $error("low byte");
  property p_pair;
    s_pair |=> rdata_o == $past(conversion_result_o[15:8], 2); endproperty
  a_pair: assert property (p_pair) else $error("high byte");
  property p_shw; wr_i && addr_i == 6'h0d ##1 !wr_i && !rd_i
    ##1 rd_i && addr_i == 6'h0d
    |=> rdata_o == $past(wdata_i, 3); endproperty
  a_shw: assert property (p_shw) else $error("shadow");
endmodule
bind arr_regs arr_regs_props #(.ACC_LIMIT(ACC_LIMIT)) i_props (.*);

// ===== bench/arr_core_model.sv
// core side bus master of the converter registers
`timescale 1ns/1ps
module arr_core_model (
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg  [5:0] addr_o = 6'h00,
  output reg  [7:0] wdata_o = 8'h00,
  output reg        wr_o = 1'b0,
  output reg        rd_o = 1'b0
);
  // one write, then an idle edge so strobes never double up
  task wr(input [5:0] a, input [7:0] d);
    addr_o <= a; wdata_o <= d; wr_o <= 1'b1;
    @(posedge clk_i); wr_o <= 1'b0; wdata_o <= ~d; addr_o <= ~a;
    @(posedge clk_i);
  endtask
  // two reads back to back, bytes returned as {b, a}
  task rd(input [5:0] a, b, output [15:0] q);
    addr_o <= a; rd_o <= 1'b1;
    @(posedge clk_i); addr_o <= b;
    #1 q[7:0] = rdata_i;
    @(posedge clk_i); rd_o <= 1'b0; addr_o <= ~b;
    #1 q[15:8] = rdata_i;
    @(posedge clk_i);
  endtask
endmodule

// ===== bench/arr_regs_bench.sv
// self-checking bench of the converter register block
`timescale 1ns/1ps
module arr_regs_bench;
  reg               clk_i = 0, rst_b_i = 0, cpu_halted_i = 0, event_i = 0;
  reg               sample_valid_i = 0, window_hit_i = 0;
  reg signed [11:0] sample_raw_i = 12'h000;
  reg        [6:0]  acc_count_i = 7'h01;
  wire       [5:0]  addr_i;
  wire       [7:0]  wdata_i, rdata_o;
  wire              wr_i, rd_i, run_o, event_o, rdy, win;
  wire       [15:0] res;
  reg        [15:0] q;
  integer           error_cnt = 0, cmp_count = 0, cyc = 0, i, k;
  initial forever #12.5 clk_i = ~clk_i;
  arr_core_model i_core (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
    .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  arr_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cpu_halted_i(cpu_halted_i), .event_i(event_i),
    .sample_valid_i(sample_valid_i), .sample_raw_i(sample_raw_i),
    .acc_count_i(acc_count_i), .window_hit_i(window_hit_i), .run_o(run_o),
    .event_o(event_o), .result_ready_flag_o(rdy),
    .window_match_flag_o(win), .conversion_result_o(res));
  task complete_run;
    $display("mismatches %0d, checks %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // n samples with events, then a bounded wait for the ready flag
  task smp(input [11:0] r, input [6:0] n, input w);
    acc_count_i <= n; window_hit_i <= w;
    @(posedge clk_i);
    for (i = 0; i < n; i++) begin
      sample_raw_i <= r; sample_valid_i <= 1'b1; event_i <= 1'b1;
      @(posedge clk_i);
    end
    sample_valid_i <= 1'b0; event_i <= 1'b0;
    for (k = 0; k < 8 && rdy !== 1'b1; k++) @(posedge clk_i);
  endtask
  // cut a hang short
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    i_core.rd(6'h0c, 6'h0d, q); chk("dbg,shadow", 16'h0000, q);
    i_core.rd(6'h10, 6'h11, q); chk("res reset", 16'h0000, q);
    i_core.wr(6'h0d, 8'ha5);
    i_core.rd(6'h0d, 6'h0d, q); chk("shadow", 16'ha5a5, q);
    smp(12'h7ff, 7'd4, 1'b0);
    i_core.rd(6'h0b, 6'h0b, q); chk("flags", 16'h0101, q);
    i_core.rd(6'h10, 6'h11, q); chk("sat", 16'd4 * 16'h03ff, q);
    i_core.rd(6'h0b, 6'h0d, q); chk("clear", 16'h0f00, q);
    smp(12'h800, 7'd1, 1'b1);
    i_core.rd(6'h0b, 6'h10, q); chk("below", 16'h0003, q);
    smp(12'h7ff, 7'h40, 1'b0);
    i_core.rd(6'h10, 6'h11, q); chk("cap", 16'd64 * 16'h03ff, q);
    cpu_halted_i <= 1'b1;
    smp(12'h100, 7'd2, 1'b0);
    i_core.rd(6'h0b, 6'h10, q); chk("halt", 16'hc000, q);
    chk("run halted", 16'h0000, {15'h0000, run_o});
    i_core.wr(6'h0c, 8'h01);
    smp(12'h100, 7'd2, 1'b0);
    i_core.rd(6'h0b, 6'h10, q); chk("dbg run", 16'h0001, q);
    chk("run kept", 16'h0001, {15'h0000, run_o});
    smp(12'h100, 7'd1, 1'b1);
    i_core.wr(6'h0b, 8'h03);
    i_core.rd(6'h0b, 6'h0b, q); chk("w1c", 16'h0000, q);
    complete_run;
  end
endmodule
